// >>> core/mcm_monitor.sv
`timescale 1ns/1ps
// Operation
// RL1: bandgap applied sets bit 6, W1C
// RL2: offset calibration done sets bit 4, W1C
// RL3: temperature out of range sets bit 0, W1C
// RL4: writing 1 to a flag advances sequence
// RL5: 3-bit period sets needed out-of-range count
// RL6: result at or above upper counts up
// RL7: result below lower counts up, else down
// RL8: voltage trim is 8-bit two's complement
// RL9: eight current trims, window picks by gain
// RL10: current trim values are 8-bit two's complement
// RL11: thresholds take only 16-bit accesses
// RL12: decode at blocking and non-blocking bases
// RL13: enabled calibration request raises interrupt
// RL14: start with shorted inputs launches calibration once
// RL15: counter floors at zero, request at period
// RL16: writing 0 keeps flags, unused bits zero
module mcm_monitor (
	input  wire logic                 CLK,
	input  wire logic                 SYS_RST,
	input  wire logic                 REG_RD,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_WIDE,
	input  wire mcm_pkg::mcm_word_type REG_ADDR,
	input  wire mcm_pkg::mcm_word_type REG_WDATA,
	output      mcm_pkg::mcm_word_type REG_RDATA,
	input  wire logic                 BANDGAP_APPLIED,
	input  wire logic                 AMP_CAL_COMPLETE,
	input  wire logic                 AMP_OFFSET_CAL_START,
	input  wire logic                 AMP_INPUT_SHORT,
	input  wire logic                 CALIBRATION_IRQ_ENABLE,
	input  wire logic                 TEMP_VALID,
	input  wire mcm_pkg::mcm_word_type TEMP_RESULT,
	input  wire mcm_pkg::mcm_sel_type  TEMP_FILTER_PERIOD,
	input  wire mcm_pkg::mcm_sel_type  CURRENT_GAIN_SELECT,
	output      mcm_pkg::mcm_byte_type VOLTAGE_OFFSET_TRIM,
	output      mcm_pkg::mcm_byte_type CURRENT_OFFSET_VALUE,
	output      logic                 AMP_CAL_LAUNCH,
	output      logic                 NEXT_CAL_STEP,
	output      logic                 CAL_IRQ
);
	import mcm_pkg::*;

	typedef struct packed {
		logic                   bandgap_flag;
		logic                   amp_done_flag;
		logic                   calreq_flag;
		mcm_word_type           upper;
		mcm_word_type           lower;
		mcm_byte_type           volt_trim;
		logic [7:0][7:0]        curr_trim;
		mcm_word_type           rdata;
		mcm_byte_type           curr_out;
		logic                   start_seen;
		logic                   launch;
		logic                   next_step;
		logic                   irq;
	} mcm_state_type;

	mcm_state_type q;
	mcm_state_type d;
	mcm_filt_if    filt_bus ();
	logic          wr_status;
	mcm_byte_type  clr;
	mcm_byte_type  status_byte;

	// RL12 one register answers in both windows
	function automatic logic reg_hit(input mcm_word_type a, input mcm_byte_type ofs);
		return (a == BLOCKING_BASE + {8'h00, ofs}) ||
			(a == NONBLOCKING_BASE + {8'h00, ofs});
	endfunction : reg_hit

	assign filt_bus.valid = TEMP_VALID;
	assign filt_bus.result = TEMP_RESULT;
	assign filt_bus.upper = q.upper;
	assign filt_bus.lower = q.lower;
	assign filt_bus.period = TEMP_FILTER_PERIOD;

	mcm_tfilt u_tfilt (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.f       (filt_bus.filt)
	);

	always_comb begin
		d = q;
		d.launch = 1'b0;
		d.next_step = 1'b0;
		wr_status = REG_WR && reg_hit(REG_ADDR, STATUS_OFS);
		// RL16 zeros in the write data clear nothing
		clr = wr_status ? (REG_WDATA[7:0] & FLAG_MASK) : 8'h00;

		// clear first, then a same-cycle event sets again so it is not lost
		// RL1 bandgap flag
		if (clr[BANDGAP_BIT]) begin
			d.bandgap_flag = 1'b0;
		end
		if (BANDGAP_APPLIED) begin
			d.bandgap_flag = 1'b1;
		end
		// RL2 offset calibration done
		if (clr[AMP_DONE_BIT]) begin
			d.amp_done_flag = 1'b0;
		end
		if (AMP_CAL_COMPLETE) begin
			d.amp_done_flag = 1'b1;
		end
		// RL3 calibration request
		if (clr[CALREQ_BIT]) begin
			d.calreq_flag = 1'b0;
		end
		if (filt_bus.request) begin
			d.calreq_flag = 1'b1;
		end
		// RL4 advance sequence
		d.next_step = |clr;

		// RL13 interrupt gated by enable
		d.irq = d.calreq_flag && CALIBRATION_IRQ_ENABLE;

		// RL14 launch only on a fresh start with inputs shorted;
		// a start raised before the short is not retried
		d.start_seen = AMP_OFFSET_CAL_START;
		d.launch = AMP_OFFSET_CAL_START && !q.start_seen && AMP_INPUT_SHORT;

		if (REG_WR) begin
			// RL11 byte writes to thresholds are dropped
			if (reg_hit(REG_ADDR, UPPER_OFS)) begin
				if (REG_WIDE) begin
					d.upper = REG_WDATA;
				end
			end else if (reg_hit(REG_ADDR, LOWER_OFS)) begin
				if (REG_WIDE) begin
					d.lower = REG_WDATA;
				end
			end else if (reg_hit(REG_ADDR, VOLT_TRIM_OFS)) begin
				// RL8 signed byte held as is
				d.volt_trim = REG_WDATA[7:0];
			end else if (reg_hit(REG_ADDR, CURR_TRIM_OFS)) begin
				// RL9 RL10 window into selected slot
				d.curr_trim[CURRENT_GAIN_SELECT] = REG_WDATA[7:0];
			end
		end

		// RL16 unused status bits read zero
		status_byte = 8'h00;
		status_byte[BANDGAP_BIT] = q.bandgap_flag;
		status_byte[AMP_DONE_BIT] = q.amp_done_flag;
		status_byte[CALREQ_BIT] = q.calreq_flag;

		if (REG_RD) begin
			if (reg_hit(REG_ADDR, STATUS_OFS)) begin
				d.rdata = {8'h00, status_byte};
			end else if (reg_hit(REG_ADDR, PERIOD_OFS)) begin
				d.rdata = {13'h0000, TEMP_FILTER_PERIOD};
			end else if (reg_hit(REG_ADDR, UPPER_OFS)) begin
				d.rdata = REG_WIDE ? q.upper : RDATA_RST;
			end else if (reg_hit(REG_ADDR, LOWER_OFS)) begin
				d.rdata = REG_WIDE ? q.lower : RDATA_RST;
			end else if (reg_hit(REG_ADDR, VOLT_TRIM_OFS)) begin
				d.rdata = {8'h00, q.volt_trim};
			end else if (reg_hit(REG_ADDR, CURR_TRIM_OFS)) begin
				d.rdata = {8'h00, q.curr_trim[CURRENT_GAIN_SELECT]};
			end else begin
				d.rdata = RDATA_RST;
			end
		end

		// RL9 trim for the gain in use
		d.curr_out = q.curr_trim[CURRENT_GAIN_SELECT];
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			q.bandgap_flag <= FLAG_RST;
			q.amp_done_flag <= FLAG_RST;
			q.calreq_flag <= FLAG_RST;
			q.upper <= UPPER_RST;
			q.lower <= LOWER_RST;
			q.volt_trim <= TRIM_RST;
			q.curr_trim <= {8{TRIM_RST}};
			q.rdata <= RDATA_RST;
			q.curr_out <= TRIM_RST;
			q.start_seen <= 1'b0;
			q.launch <= 1'b0;
			q.next_step <= 1'b0;
			q.irq <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign REG_RDATA = q.rdata;
	assign VOLTAGE_OFFSET_TRIM = q.volt_trim;
	assign CURRENT_OFFSET_VALUE = q.curr_out;
	assign AMP_CAL_LAUNCH = q.launch;
	assign NEXT_CAL_STEP = q.next_step;
	assign CAL_IRQ = q.irq;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_bandgap_set: assert property ( // RL1
		BANDGAP_APPLIED |=> q.bandgap_flag)
		else $error("bandgap flag not set");
	a_bandgap_clear: assert property ( // RL1
		q.bandgap_flag && wr_status && REG_WDATA[6] && !BANDGAP_APPLIED
		|=> !q.bandgap_flag)
		else $error("bandgap flag not cleared by write one");
	a_amp_done_set: assert property ( // RL2
		AMP_CAL_COMPLETE |=> q.amp_done_flag)
		else $error("offset calibration done flag not set");
	a_amp_done_clear: assert property ( // RL2
		wr_status && REG_WDATA[4] && !AMP_CAL_COMPLETE |=> !q.amp_done_flag)
		else $error("offset calibration done flag not cleared");
	a_calreq_set: assert property ( // RL3
		filt_bus.request |=> q.calreq_flag)
		else $error("calibration request flag not set");
	a_next_step_pulse: assert property ( // RL4
		wr_status && (REG_WDATA[7:0] & FLAG_MASK) != 8'h00 |=> NEXT_CAL_STEP ##1 !NEXT_CAL_STEP
		or (wr_status ##1 NEXT_CAL_STEP))
		else $error("flag write did not advance sequence");
	a_zero_keeps_flags: assert property ( // RL16
		q.calreq_flag && wr_status && !REG_WDATA[0] |=> q.calreq_flag)
		else $error("writing zero changed a flag");
	a_status_unused_zero: assert property ( // RL16
		REG_RD && reg_hit(REG_ADDR, STATUS_OFS) |=> (REG_RDATA & 16'hFFAE) == 16'h0000)
		else $error("unused status bit read nonzero");
	a_irq_gate: assert property ( // RL13
		!CALIBRATION_IRQ_ENABLE |=> !CAL_IRQ)
		else $error("interrupt raised while disabled");
	a_irq_raise: assert property ( // RL13
		filt_bus.request && CALIBRATION_IRQ_ENABLE |=> CAL_IRQ)
		else $error("enabled request gave no interrupt");
	a_launch_once: assert property ( // RL14
		AMP_CAL_LAUNCH |=> !AMP_CAL_LAUNCH)
		else $error("calibration launched twice");
	a_launch_needs_short: assert property ( // RL14
		!AMP_INPUT_SHORT |=> !AMP_CAL_LAUNCH)
		else $error("calibration launched with open inputs");
	a_trim_window: assert property ( // RL9
		REG_WR && reg_hit(REG_ADDR, CURR_TRIM_OFS) ##1 $stable(CURRENT_GAIN_SELECT)
		|=> CURRENT_OFFSET_VALUE == $past(REG_WDATA[7:0], 2))
		else $error("current trim window shows wrong slot");
	a_volt_trim_store: assert property ( // RL8
		REG_WR && reg_hit(REG_ADDR, VOLT_TRIM_OFS) |=> VOLTAGE_OFFSET_TRIM == $past(REG_WDATA[7:0]))
		else $error("voltage trim not stored");
	a_threshold_byte: assert property ( // RL11
		REG_WR && !REG_WIDE && reg_hit(REG_ADDR, UPPER_OFS) |=> $stable(q.upper))
		else $error("byte write changed a threshold");
	a_nonblocking_decode: assert property ( // RL12
		REG_RD && REG_ADDR == NONBLOCKING_BASE + {8'h00, STATUS_OFS}
		|=> REG_RDATA[7:0] == $past(status_byte))
		else $error("non-blocking window not decoded");
	a_bandgap_hold: assert property ( // RL1
		q.bandgap_flag && !clr[BANDGAP_BIT] |=> q.bandgap_flag)
		else $error("bandgap flag dropped without a clear");
	a_bandgap_idle: assert property ( // RL1
		!q.bandgap_flag && !BANDGAP_APPLIED |=> !q.bandgap_flag)
		else $error("bandgap flag set without the reference");
	a_amp_done_hold: assert property ( // RL2
		q.amp_done_flag && !clr[AMP_DONE_BIT] |=> q.amp_done_flag)
		else $error("offset calibration done flag dropped");
	a_amp_done_idle: assert property ( // RL2
		!q.amp_done_flag && !AMP_CAL_COMPLETE |=> !q.amp_done_flag)
		else $error("offset calibration done flag set early");
	a_calreq_hold: assert property ( // RL3
		q.calreq_flag && !clr[CALREQ_BIT] |=> q.calreq_flag)
		else $error("calibration request flag dropped");
	a_calreq_clear: assert property ( // RL3
		q.calreq_flag && clr[CALREQ_BIT] && !filt_bus.request |=> !q.calreq_flag)
		else $error("calibration request flag not cleared");
	a_calreq_idle: assert property ( // RL3
		!q.calreq_flag && !filt_bus.request |=> !q.calreq_flag)
		else $error("calibration request flag set without a request");
	a_step_idle: assert property ( // RL4
		clr == 8'h00 |=> !NEXT_CAL_STEP)
		else $error("sequence advanced without a flag write");
	a_request_count_reset: assert property ( // RL15
		filt_bus.request |-> filt_bus.count == COUNT_RST)
		else $error("filter counter kept its value after a request");
	a_irq_hold: assert property ( // RL13
		q.calreq_flag && !clr[CALREQ_BIT] && CALIBRATION_IRQ_ENABLE |=> CAL_IRQ)
		else $error("enabled pending request lost its interrupt");
	a_launch_cause: assert property ( // RL14
		AMP_CAL_LAUNCH |-> $past(AMP_OFFSET_CAL_START) && $past(AMP_INPUT_SHORT))
		else $error("calibration launched without start and short");
	a_launch_fresh: assert property ( // RL14
		AMP_OFFSET_CAL_START && !q.start_seen && AMP_INPUT_SHORT |=> AMP_CAL_LAUNCH)
		else $error("fresh start did not launch calibration");
	a_upper_store: assert property ( // RL6
		REG_WR && REG_WIDE && reg_hit(REG_ADDR, UPPER_OFS) |=> q.upper == $past(REG_WDATA))
		else $error("upper threshold not stored");
	a_lower_store: assert property ( // RL7
		REG_WR && REG_WIDE && reg_hit(REG_ADDR, LOWER_OFS) |=> q.lower == $past(REG_WDATA))
		else $error("lower threshold not stored");
	a_lower_byte_drop: assert property ( // RL11
		REG_WR && !REG_WIDE && reg_hit(REG_ADDR, LOWER_OFS) |=> $stable(q.lower))
		else $error("byte write changed the lower threshold");
	a_period_readback: assert property ( // RL5
		REG_RD && reg_hit(REG_ADDR, PERIOD_OFS)
		|=> REG_RDATA == {13'h0000, $past(TEMP_FILTER_PERIOD)})
		else $error("filter period read back wrong");
	a_unmapped_read: assert property ( // RL12
		REG_RD && REG_ADDR[15:8] != BLOCKING_BASE[15:8]
		&& REG_ADDR[15:8] != NONBLOCKING_BASE[15:8] |=> REG_RDATA == RDATA_RST)
		else $error("address outside both windows answered");
	a_volt_trim_hold: assert property ( // RL8
		!(REG_WR && reg_hit(REG_ADDR, VOLT_TRIM_OFS)) |=> $stable(VOLTAGE_OFFSET_TRIM))
		else $error("voltage trim changed without a write");
	a_curr_trim_follow: assert property ( // RL9
		1'b1 |=> CURRENT_OFFSET_VALUE == $past(q.curr_trim[CURRENT_GAIN_SELECT]))
		else $error("current trim output not the selected slot");
endmodule : mcm_monitor

// >>> core/mcm_pkg.sv
package mcm_pkg;
	typedef logic [15:0] mcm_word_type;
	typedef logic [7:0]  mcm_byte_type;
	typedef logic [2:0]  mcm_sel_type;

	// global address space windows
	localparam mcm_word_type BLOCKING_BASE    = 16'h0200;
	localparam mcm_word_type NONBLOCKING_BASE = 16'h0300;

	// register offsets
	localparam mcm_byte_type STATUS_OFS    = 8'hA2;
	localparam mcm_byte_type PERIOD_OFS    = 8'hA3;
	localparam mcm_byte_type UPPER_OFS     = 8'hA4;
	localparam mcm_byte_type LOWER_OFS     = 8'hA6;
	localparam mcm_byte_type VOLT_TRIM_OFS = 8'hA8;
	localparam mcm_byte_type CURR_TRIM_OFS = 8'hAA;

	// status field positions
	localparam int unsigned BANDGAP_BIT = 6;
	localparam int unsigned AMP_DONE_BIT = 4;
	localparam int unsigned CALREQ_BIT  = 0;
	localparam mcm_byte_type FLAG_MASK  = 8'h51;

	// reset values
	localparam logic         FLAG_RST   = 1'b0;
	localparam mcm_word_type UPPER_RST  = 16'h0000;
	localparam mcm_word_type LOWER_RST  = 16'h0000;
	localparam mcm_byte_type TRIM_RST   = 8'h00;
	localparam mcm_sel_type  COUNT_RST  = 3'h0;
	localparam mcm_word_type RDATA_RST  = 16'h0000;

	// two's complement trim limits
	localparam mcm_byte_type TRIM_MAX = 8'h7F;
	localparam mcm_byte_type TRIM_MIN = 8'h80;
endpackage : mcm_pkg

// >>> core/mcm_filt_if.sv
`timescale 1ns/1ps
interface mcm_filt_if;
	import mcm_pkg::*;
	logic         valid;
	mcm_word_type result;
	mcm_word_type upper;
	mcm_word_type lower;
	mcm_sel_type  period;
	logic         request;
	mcm_sel_type  count;

	modport ctrl (output valid, output result, output upper, output lower,
		output period, input request, input count);
	modport filt (input valid, input result, input upper, input lower,
		input period, output request, output count);
endinterface : mcm_filt_if

// >>> core/mcm_tfilt.sv
`timescale 1ns/1ps
module mcm_tfilt (
	input  wire logic CLK,
	input  wire logic SYS_RST,
	mcm_filt_if.filt  f
);
	import mcm_pkg::*;

	typedef struct packed {
		mcm_sel_type count;
		logic        request;
	} mcm_filt_state_type;

	mcm_filt_state_type q;
	mcm_filt_state_type d;
	logic               outside;
	logic [3:0]         bumped;

	always_comb begin
		d = q;
		d.request = 1'b0;
		// RL6 RL7 out of either window
		outside = (f.result >= f.upper) || (f.result < f.lower);
		bumped = {1'b0, q.count} + 4'h1;
		if (f.valid) begin
			if (outside) begin
				// RL5 RL15 period reached
				if (bumped >= {1'b0, f.period}) begin
					d.request = 1'b1;
					d.count = COUNT_RST;
				end else begin
					d.count = bumped[2:0];
				end
			end else if (q.count != COUNT_RST) begin
				// RL15 floor at zero
				d.count = q.count - 3'h1;
			end
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			q.count <= COUNT_RST;
			q.request <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign f.request = q.request;
	assign f.count = q.count;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_count_floor_zero: assert property ( // RL15
		f.valid && !outside && q.count == 3'h0 |=> q.count == 3'h0 && !q.request)
		else $error("filter counter went below zero");
	a_upper_hit_request: assert property ( // RL6
		f.valid && f.result >= f.upper && f.period == 3'h1 && q.count == 3'h0
		|=> q.request && q.count == 3'h0)
		else $error("upper threshold hit did not request");
	a_lower_hit_count: assert property ( // RL7
		f.valid && f.result < f.lower && f.period == 3'h3 && q.count == 3'h1
		|=> !q.request && q.count == 3'h2)
		else $error("lower threshold hit did not count up");
	a_inside_decrement: assert property ( // RL7
		f.valid && !outside && q.count == 3'h2 |=> q.count == 3'h1 && !q.request)
		else $error("in range result did not count down");
	a_no_spurious_request: assert property ( // RL5
		!f.valid |=> !q.request)
		else $error("request without a temperature result");
endmodule : mcm_tfilt

// >>> dv/mcm_monitor_bench.sv
`timescale 1ns/1ps
module mcm_monitor_bench;
	import mcm_pkg::*;
	logic         CLK = 1'b0;
	logic         SYS_RST = 1'b1;
	logic         REG_RD = 1'b0;
	logic         REG_WR = 1'b0;
	logic         REG_WIDE = 1'b1;
	mcm_word_type REG_ADDR = 16'h0000;
	mcm_word_type REG_WDATA = 16'h0000;
	mcm_word_type REG_RDATA;
	logic         BANDGAP_APPLIED = 1'b0;
	logic         AMP_CAL_COMPLETE = 1'b0;
	logic         AMP_OFFSET_CAL_START = 1'b0;
	logic         AMP_INPUT_SHORT = 1'b0;
	logic         CALIBRATION_IRQ_ENABLE = 1'b0;
	logic         TEMP_VALID = 1'b0;
	mcm_word_type TEMP_RESULT = 16'h0000;
	mcm_sel_type  TEMP_FILTER_PERIOD = 3'h0;
	mcm_sel_type  CURRENT_GAIN_SELECT = 3'h0;
	mcm_byte_type VOLTAGE_OFFSET_TRIM;
	mcm_byte_type CURRENT_OFFSET_VALUE;
	logic         AMP_CAL_LAUNCH;
	logic         NEXT_CAL_STEP;
	logic         CAL_IRQ;
	int           num_errors = 0;
	int           cmp_count = 0;
	int           cycles = 0;
	logic         step;
	mcm_word_type rv;
	int           n;

	mcm_monitor i_mcm_monitor (.CLK(CLK), .SYS_RST(SYS_RST), .REG_RD(REG_RD), .REG_WR(REG_WR),
		.REG_WIDE(REG_WIDE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.BANDGAP_APPLIED(BANDGAP_APPLIED), .AMP_CAL_COMPLETE(AMP_CAL_COMPLETE),
		.AMP_OFFSET_CAL_START(AMP_OFFSET_CAL_START), .AMP_INPUT_SHORT(AMP_INPUT_SHORT),
		.CALIBRATION_IRQ_ENABLE(CALIBRATION_IRQ_ENABLE), .TEMP_VALID(TEMP_VALID),
		.TEMP_RESULT(TEMP_RESULT), .TEMP_FILTER_PERIOD(TEMP_FILTER_PERIOD),
		.CURRENT_GAIN_SELECT(CURRENT_GAIN_SELECT), .VOLTAGE_OFFSET_TRIM(VOLTAGE_OFFSET_TRIM),
		.CURRENT_OFFSET_VALUE(CURRENT_OFFSET_VALUE), .AMP_CAL_LAUNCH(AMP_CAL_LAUNCH),
		.NEXT_CAL_STEP(NEXT_CAL_STEP), .CAL_IRQ(CAL_IRQ));

	always #4 CLK = ~CLK;

	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	// the whole run needs well under a thousand cycles
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// write strobe for one cycle; step output sampled after the taking edge
	task automatic wr(input mcm_word_type a, input mcm_word_type d, input logic w);
		@(posedge CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WIDE <= w;
		@(posedge CLK);
		REG_WR <= 1'b0;
		#1 step = NEXT_CAL_STEP;
	endtask : wr

	task automatic rd(input mcm_word_type a, input logic w, output mcm_word_type d);
		@(posedge CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		REG_WIDE <= w;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask : rd

	task automatic temp(input mcm_word_type v);
		@(posedge CLK);
		TEMP_VALID <= 1'b1;
		TEMP_RESULT <= v;
		@(posedge CLK);
		TEMP_VALID <= 1'b0;
	endtask : temp

	task automatic launches(output int k);
		k = 0;
		repeat (4) begin
			@(posedge CLK);
			#1 if (AMP_CAL_LAUNCH === 1'b1) k++;
		end
	endtask : launches

	initial begin
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		rd(16'h02A2, 1'b1, rv); check("status reset", rv, 16'h0000);
		rd(16'h03A4, 1'b1, rv); check("upper reset", rv, 16'h0000);
		rd(16'h02A6, 1'b1, rv); check("lower reset", rv, 16'h0000);
		rd(16'h02B0, 1'b1, rv); check("unmapped", rv, 16'h0000);
		rd(16'h04A2, 1'b1, rv); check("outside base", rv, 16'h0000);
		$display("test reset done");
		@(posedge CLK) BANDGAP_APPLIED <= 1'b1;
		@(posedge CLK) BANDGAP_APPLIED <= 1'b0;
		rd(16'h03A2, 1'b0, rv); check("bandgap flag", rv, 16'h0040);
		wr(16'h02A2, 16'h00AE, 1'b0); check("no step", {15'h0, step}, 16'h0000);
		rd(16'h02A2, 1'b0, rv); check("zero write keeps", rv, 16'h0040);
		wr(16'h02A2, 16'h0040, 1'b0); check("step bandgap", {15'h0, step}, 16'h0001);
		rd(16'h02A2, 1'b0, rv); check("bandgap clear", rv, 16'h0000);
		@(posedge CLK) AMP_CAL_COMPLETE <= 1'b1;
		@(posedge CLK) AMP_CAL_COMPLETE <= 1'b0;
		rd(16'h02A2, 1'b0, rv); check("amp done flag", rv, 16'h0010);
		wr(16'h03A2, 16'h0010, 1'b0); check("step amp", {15'h0, step}, 16'h0001);
		rd(16'h02A2, 1'b0, rv); check("amp done clear", rv, 16'h0000);
		$display("test flags done");
		@(posedge CLK) AMP_INPUT_SHORT <= 1'b1;
		@(posedge CLK) AMP_OFFSET_CAL_START <= 1'b1;
		launches(n); check("launch once", 16'(n), 16'h0001);
		launches(n); check("held start", 16'(n), 16'h0000);
		@(posedge CLK) begin
			AMP_OFFSET_CAL_START <= 1'b0;
			AMP_INPUT_SHORT <= 1'b0;
		end
		@(posedge CLK) AMP_OFFSET_CAL_START <= 1'b1;
		launches(n); check("no short", 16'(n), 16'h0000);
		@(posedge CLK) AMP_OFFSET_CAL_START <= 1'b0;
		$display("test launch done");
		wr(16'h02A4, 16'h0100, 1'b1);
		wr(16'h02A6, 16'h0080, 1'b1);
		wr(16'h02A4, 16'h0033, 1'b0);
		rd(16'h02A4, 1'b1, rv); check("upper", rv, 16'h0100);
		rd(16'h03A6, 1'b1, rv); check("lower", rv, 16'h0080);
		@(posedge CLK) TEMP_FILTER_PERIOD <= 3'h3;
		wr(16'h02A3, 16'h0007, 1'b0);
		rd(16'h02A3, 1'b0, rv); check("period", rv, 16'h0003);
		@(posedge CLK) CALIBRATION_IRQ_ENABLE <= 1'b1;
		// equal to upper counts, equal to lower does not; counter floors at zero
		temp(16'h0100);
		temp(16'h0080);
		temp(16'h0080);
		temp(16'h0100);
		temp(16'h007F);
		repeat (3) @(posedge CLK);
		#1 check("irq early", {15'h0, CAL_IRQ}, 16'h0000);
		rd(16'h02A2, 1'b0, rv); check("no request", rv, 16'h0000);
		temp(16'h0100);
		repeat (3) @(posedge CLK);
		#1 check("irq", {15'h0, CAL_IRQ}, 16'h0001);
		rd(16'h02A2, 1'b0, rv); check("request flag", rv, 16'h0001);
		@(posedge CLK) CALIBRATION_IRQ_ENABLE <= 1'b0;
		repeat (2) @(posedge CLK);
		#1 check("irq masked", {15'h0, CAL_IRQ}, 16'h0000);
		wr(16'h02A2, 16'h0001, 1'b0); check("step request", {15'h0, step}, 16'h0001);
		rd(16'h02A2, 1'b0, rv); check("request clear", rv, 16'h0000);
		// a period of one asks on the first hit
		@(posedge CLK) TEMP_FILTER_PERIOD <= 3'h1;
		temp(16'h0100);
		rd(16'h02A2, 1'b0, rv); check("single hit", rv, 16'h0001);
		wr(16'h02A2, 16'h0001, 1'b0);
		rd(16'h02A2, 1'b0, rv); check("single clear", rv, 16'h0000);
		$display("test filter done");
		wr(16'h02A8, 16'h007F, 1'b0);
		rd(16'h02A8, 1'b0, rv); check("volt max", rv, 16'h007F);
		wr(16'h02A8, 16'h0080, 1'b1);
		rd(16'h02A8, 1'b1, rv); check("volt min", rv, 16'h0080);
		check("volt out", {8'h00, VOLTAGE_OFFSET_TRIM}, 16'h0080);
		for (int g = 0; g < 8; g++) begin
			@(posedge CLK) CURRENT_GAIN_SELECT <= 3'(g);
			wr(16'h02AA, {8'h00, TRIM_MAX + 8'(g)}, 1'b0);
		end
		for (int g = 0; g < 8; g++) begin
			@(posedge CLK) CURRENT_GAIN_SELECT <= 3'(7 - g);
			rd(16'h03AA, 1'b0, rv); check("window", rv, {8'h00, TRIM_MAX + 8'(7 - g)});
			check("current out", 16'(CURRENT_OFFSET_VALUE), 16'(TRIM_MAX + 8'(7 - g)));
		end
		$display("test trims done");
		summarize();
	end
endmodule : mcm_monitor_bench
